// >>> btg_piezo_model.sv
// Model of the transistor and piezo hanging on the buzzer pin
`default_nettype none
`timescale 1ns/1ps

module btg_piezo_model (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst_b,
    // Buzzer pin, the transistor conducts while it is low
    input  wire logic tone_output_pin,
    // Pulse timing in system clocks
    output var  int   last_low,
    output var  int   last_period,
    output var  int   pulses
);

    int   since_fall;
    logic pin_q;

    // Timing runs from each falling edge; the first period after a pause is bogus by nature
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pin_q       <= 1'b1;
            since_fall  <= 0;
            last_low    <= 0;
            last_period <= 0;
            pulses      <= 0;
        end else begin
            pin_q      <= tone_output_pin;
            since_fall <= since_fall + 1;
            if (pin_q && !tone_output_pin) begin
                last_period <= since_fall + 1;
                since_fall  <= 0;
                pulses      <= pulses + 1;
            end
            if (!pin_q && tone_output_pin) begin
                last_low <= since_fall + 1;
            end
        end
    end

endmodule : btg_piezo_model

`default_nettype wire

// >>> btg_pkg.sv
// Shared constants, types and helpers of the buzzer tone generator
`default_nettype none

package btg_pkg;

    // Register bus
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 4;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } btg_bus_req_t;

    // Register offsets
    localparam logic [ADDR_W-1:0] ENV_CTRL_ADDR  = 16'hff6c;
    localparam logic [ADDR_W-1:0] ONE_SHOT_ADDR  = 16'hff6d;
    localparam logic [ADDR_W-1:0] FREQ_SEL_ADDR  = 16'hff6e;
    localparam logic [ADDR_W-1:0] DUTY_SEL_ADDR  = 16'hff6f;

    // Field positions, envelope_and_enable_control
    localparam int unsigned BIT_OUT_EN       = 0;
    localparam int unsigned BIT_ENV_EN       = 1;
    localparam int unsigned BIT_ENV_RESTART  = 2;
    localparam int unsigned BIT_ENV_STEP_SEL = 3;
    // Field positions, one_shot_control
    localparam int unsigned BIT_PULSE_LEN    = 0;
    localparam int unsigned BIT_PULSE_TRIG   = 1;
    localparam int unsigned BIT_PULSE_ABORT  = 2;

    // Reset values
    localparam logic [2:0] SEL_RESET   = 3'h0;
    localparam logic       FLAG_RESET  = 1'b0;
    localparam logic [2:0] LEVEL_MAX   = 3'h0;
    localparam logic [2:0] LEVEL_MIN   = 3'h7;

    // Time base: both edges of the 32.768 kHz oscillator give half ticks
    localparam int unsigned OSC_HZ        = 32768;
    localparam int unsigned HALF_TICK_HZ  = 2 * OSC_HZ;
    localparam int unsigned SYNC_HZ       = 256;
    localparam int unsigned SYNC_DIV      = HALF_TICK_HZ / SYNC_HZ;
    localparam int unsigned ENV_FAST_US   = 62500;
    localparam int unsigned ENV_SLOW_US   = 125000;
    localparam int unsigned PULSE_SHORT_US = 31250;
    localparam int unsigned PULSE_LONG_US  = 125000;
    // The slow step is 8192 half ticks, one more than 13 bits can hold
    localparam logic [13:0] ENV_FAST_HT   = 14'(ENV_FAST_US * 64'(HALF_TICK_HZ) / 1000000);
    localparam logic [13:0] ENV_SLOW_HT   = 14'(ENV_SLOW_US * 64'(HALF_TICK_HZ) / 1000000);
    localparam logic [5:0]  PULSE_SHORT_T = 6'(PULSE_SHORT_US * SYNC_HZ / 1000000);
    localparam logic [5:0]  PULSE_LONG_T  = 6'(PULSE_LONG_US * SYNC_HZ / 1000000);
    localparam logic [7:0]  SYNC_LAST     = 8'(SYNC_DIV - 1);

    // Tone period in half ticks for the low four selections
    localparam logic [5:0] PERIOD_16 = 6'h10;
    localparam logic [5:0] PERIOD_20 = 6'h14;
    localparam logic [5:0] PERIOD_24 = 6'h18;
    localparam logic [5:0] PERIOD_28 = 6'h1c;
    localparam logic [5:0] HIGH_BASE_LO = 6'h08;
    localparam logic [5:0] HIGH_BASE_HI = 6'h0c;

    typedef enum logic [1:0] {
        OS_IDLE,
        OS_WAIT,
        OS_RUN
    } btg_os_state_t;

    function automatic logic [5:0] btg_period(input logic [2:0] sel);
        logic [5:0] base;
        base = PERIOD_16;
        case (sel[1:0])
            2'h0: base = PERIOD_16;
            2'h1: base = PERIOD_20;
            2'h2: base = PERIOD_24;
            default: base = PERIOD_28;
        endcase
        return sel[2] ? 6'(base << 1) : base;
    endfunction : btg_period

    function automatic logic [5:0] btg_active_len(input logic [2:0] sel, input logic [2:0] level);
        logic [5:0] n;
        n = (sel[1] ? HIGH_BASE_HI : HIGH_BASE_LO) - {3'h0, level};
        return sel[2] ? 6'(n << 1) : n;
    endfunction : btg_active_len

endpackage : btg_pkg

`default_nettype wire

// >>> btg_top.sv
// Buzzer tone generator: registers, envelope, one-shot and pin drive
// Contract
// - Output enable drives tone on pin; disabled pin stays high except during a one-shot burst; bit reads back.
// - Frequency select divides oscillator into eight tones from 4096.0 to 1170.3 Hz.
// - Duty level n gives (8-n) or (12-n) parts of 16, 20, 24, 28.
// - With envelope on, duty comes from the envelope, not the duty select.
// - Envelope restart returns to maximum; ignored if envelope off and silent; reads 0.
// - Envelope enable applies decaying duty while tone is out; bit reads back. The level steps only under continuous output, not in a one-shot.
// - Envelope steps every 125 ms if step select is 1, else 62.5 ms.
// - Pulse length select gives 125 ms or 31.25 ms one-shot, continuous unaffected.
// - Trigger write starts a one-shot burst that ends after the selected length.
// - Trigger ignored while continuous output is enabled.
// - Retrigger during a burst restarts the full length from then.
// - Trigger status reads 1 while a burst runs, 0 when ready.
// - Abort during a burst ends it early; otherwise no effect; reads 0.
// - Bit 3 of one-shot, frequency and duty registers has no storage, reads 0.
// - Reset clears every control field and the busy status.
// - Enabling output with envelope on starts at level 0, steps to 7, holds.
// - One-shot start and end, early stop included, align to the 256 Hz tick.
//
// The plain strobed port is this design's own decision.
`default_nettype none
`timescale 1ns/1ps

module btg_top
    import btg_pkg::*;
(
    // Clock, reset and clock enable
    input  wire logic              clock,
    input  wire logic              rst_b,
    input  wire logic              ce,
    // Register port
    input  wire btg_bus_req_t      bus_req,
    output logic [DATA_W-1:0]      rd_data,
    // Oscillator pin, 32.768 kHz
    input  wire logic              osc_in,
    // Buzzer pin, high when inactive
    output logic                   tone_output_pin
);

    ////////////////////////////////////////////////////////////////////////////////
    // Oscillator synchroniser and time base

    logic        osc_s1_ff;
    logic        osc_s2_ff;
    logic        osc_s3_ff;
    logic        osc_lvl_ff;
    logic        half_tick;
    logic [7:0]  sync_cnt_ff;
    logic        tick256;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            osc_s1_ff  <= 1'b0;
            osc_s2_ff  <= 1'b0;
            osc_s3_ff  <= 1'b0;
            osc_lvl_ff <= 1'b0;
        end else if (ce) begin
            osc_s1_ff <= osc_in;
            osc_s2_ff <= osc_s1_ff;
            osc_s3_ff <= osc_s2_ff;
            if (osc_s2_ff == osc_s3_ff) begin
                osc_lvl_ff <= osc_s3_ff;
            end
        end
    end

    // Both oscillator edges count, giving the resolution the duty tables need
    assign half_tick = (osc_s2_ff == osc_s3_ff) && (osc_s3_ff != osc_lvl_ff);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sync_cnt_ff <= 8'h00;
        end else if (ce && half_tick) begin
            sync_cnt_ff <= sync_cnt_ff + 8'h01;
        end
    end

    assign tick256 = half_tick && (sync_cnt_ff == SYNC_LAST);

    ////////////////////////////////////////////////////////////////////////////////
    // Register decode

    logic wr_env;
    logic wr_os;
    logic wr_freq;
    logic wr_duty;

    assign wr_env  = bus_req.wr && (bus_req.addr == ENV_CTRL_ADDR);
    assign wr_os   = bus_req.wr && (bus_req.addr == ONE_SHOT_ADDR);
    assign wr_freq = bus_req.wr && (bus_req.addr == FREQ_SEL_ADDR);
    assign wr_duty = bus_req.wr && (bus_req.addr == DUTY_SEL_ADDR);

    logic       out_en_ff;
    logic       env_en_ff;
    logic       env_step_sel_ff;
    logic       pulse_len_ff;
    logic [2:0] freq_sel_ff;
    logic [2:0] duty_sel_ff;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            out_en_ff       <= FLAG_RESET;
            env_en_ff       <= FLAG_RESET;
            env_step_sel_ff <= FLAG_RESET;
            pulse_len_ff    <= FLAG_RESET;
            freq_sel_ff     <= SEL_RESET;
            duty_sel_ff     <= SEL_RESET;
        end else if (ce) begin
            if (wr_env) begin
                out_en_ff       <= bus_req.wdata[BIT_OUT_EN];
                env_en_ff       <= bus_req.wdata[BIT_ENV_EN];
                env_step_sel_ff <= bus_req.wdata[BIT_ENV_STEP_SEL];
            end
            if (wr_os) begin
                pulse_len_ff <= bus_req.wdata[BIT_PULSE_LEN];
            end
            if (wr_freq) begin
                freq_sel_ff <= bus_req.wdata[2:0];
            end
            if (wr_duty) begin
                duty_sel_ff <= bus_req.wdata[2:0];
            end
        end
    end

    // Action bits are never stored: each write of 1 is a single pulse
    logic env_restart_wr;
    logic trig_wr;
    logic abort_wr;

    assign env_restart_wr = wr_env && bus_req.wdata[BIT_ENV_RESTART];
    assign trig_wr        = wr_os && bus_req.wdata[BIT_PULSE_TRIG];
    assign abort_wr       = wr_os && bus_req.wdata[BIT_PULSE_ABORT];

    ////////////////////////////////////////////////////////////////////////////////
    // One-shot sequencer

    btg_os_state_t os_state_ff;
    logic          pend_trig_ff;
    logic          pend_stop_ff;
    logic [5:0]    os_left_ff;
    logic          os_busy;
    logic          trig_ok;
    logic          abort_ok;

    assign os_busy  = (os_state_ff != OS_IDLE);
    assign trig_ok  = trig_wr && !out_en_ff;
    assign abort_ok = abort_wr && os_busy && !trig_ok;

    // Requests are parked until the next 256 Hz tick; a trigger beats an abort
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pend_trig_ff <= 1'b0;
            pend_stop_ff <= 1'b0;
        end else if (ce) begin
            if (trig_ok) begin
                pend_trig_ff <= 1'b1;
                pend_stop_ff <= 1'b0;
            end else if (abort_ok) begin
                pend_trig_ff <= 1'b0;
                pend_stop_ff <= 1'b1;
            end else if (tick256) begin
                pend_trig_ff <= 1'b0;
                pend_stop_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            os_state_ff <= OS_IDLE;
            os_left_ff  <= 6'h00;
        end else if (ce) begin
            case (os_state_ff)
                OS_IDLE: begin
                    if (trig_ok) begin
                        os_state_ff <= OS_WAIT;
                    end
                end
                OS_WAIT, OS_RUN: begin
                    if (tick256 && !trig_ok) begin
                        if (pend_trig_ff) begin
                            os_state_ff <= OS_RUN;
                            os_left_ff  <= pulse_len_ff ? PULSE_LONG_T : PULSE_SHORT_T;
                        end else if (pend_stop_ff || (os_left_ff == 6'h01)) begin
                            os_state_ff <= OS_IDLE;
                            os_left_ff  <= 6'h00;
                        end else if (os_state_ff == OS_RUN) begin
                            os_left_ff <= os_left_ff - 6'h01;
                        end
                    end
                end
                default: begin
                    os_state_ff <= OS_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Digital envelope

    logic       tone_run;
    logic       env_restart_ok;
    logic       out_en_rise;
    logic [2:0] env_level_ff;
    logic [13:0] env_cnt_ff;
    logic [13:0] env_limit;

    assign tone_run       = out_en_ff || (os_state_ff == OS_RUN);
    assign env_restart_ok = env_restart_wr && (env_en_ff || tone_run);
    assign out_en_rise    = wr_env && bus_req.wdata[BIT_OUT_EN] && !out_en_ff;
    assign env_limit      = env_step_sel_ff ? ENV_SLOW_HT : ENV_FAST_HT;

    // Steps only under continuous output; a one-shot burst on its own never steps it
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            env_level_ff <= LEVEL_MAX;
            env_cnt_ff   <= 14'h0000;
        end else if (ce) begin
            if (env_restart_ok || out_en_rise) begin
                env_level_ff <= LEVEL_MAX;
                env_cnt_ff   <= 14'h0000;
            end else if (env_en_ff && out_en_ff && half_tick) begin
                if (env_cnt_ff == env_limit - 14'h0001) begin
                    env_cnt_ff <= 14'h0000;
                    if (env_level_ff != LEVEL_MIN) begin
                        env_level_ff <= env_level_ff + 3'h1;
                    end
                end else begin
                    env_cnt_ff <= env_cnt_ff + 14'h0001;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Waveform and pin

    logic [2:0] level_sel;
    logic       wave;
    logic       pin_ff;

    assign level_sel = env_en_ff ? env_level_ff : duty_sel_ff;

    btg_wave u_wave (
        .clock     (clock),
        .rst_b     (rst_b),
        .ce        (ce),
        .half_tick (half_tick),
        .run       (tone_run),
        .freq_sel  (freq_sel_ff),
        .level     (level_sel),
        .wave      (wave)
    );

    // Active part of the wave pulls the pin low; idle pin rests high
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pin_ff <= 1'b1;
        end else if (ce) begin
            pin_ff <= !(tone_run && wave);
        end
    end

    assign tone_output_pin = pin_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Read-back

    logic [DATA_W-1:0] rd_data_ff;
    logic [DATA_W-1:0] nxt_rd_data;

    always_comb begin
        nxt_rd_data = 4'h0;
        case (bus_req.addr)
            ENV_CTRL_ADDR: nxt_rd_data = {env_step_sel_ff, 1'b0, env_en_ff, out_en_ff};
            ONE_SHOT_ADDR: nxt_rd_data = {2'b00, os_busy, pulse_len_ff};
            FREQ_SEL_ADDR: nxt_rd_data = {1'b0, freq_sel_ff};
            DUTY_SEL_ADDR: nxt_rd_data = {1'b0, duty_sel_ff};
            default:       nxt_rd_data = 4'h0;
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rd_data_ff <= 4'h0;
        end else if (ce) begin
            rd_data_ff <= bus_req.rd ? nxt_rd_data : 4'h0;
        end
    end

    assign rd_data = rd_data_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b || !ce);

    sequence s_trig_taken;
        trig_ok && (os_state_ff == OS_IDLE);
    endsequence

    // The wait for the 256 Hz tick can outlast any fixed bound, so each step is checked alone
    sequence s_run_started;
        (os_state_ff == OS_WAIT) && tick256 && pend_trig_ff && !trig_ok;
    endsequence

    chk_pin_idle_high: assert property (
        !tone_run |=> tone_output_pin)
        else $error("pin not high while tone is off");

    chk_trig_blocked: assert property (
        (trig_wr && out_en_ff && !os_busy) |=> !os_busy)
        else $error("trigger accepted during continuous output");

    chk_trig_wait: assert property (
        s_trig_taken |=> (os_state_ff == OS_WAIT))
        else $error("one-shot did not wait for tick after trigger");

    chk_run_start: assert property (
        s_run_started |=> (os_state_ff == OS_RUN))
        else $error("one-shot did not start on the tick");

    chk_busy_read: assert property (
        (bus_req.rd && bus_req.addr == ONE_SHOT_ADDR) |=> (rd_data[1] == $past(os_busy)))
        else $error("busy status read wrong");

    chk_abort_idle: assert property (
        (abort_wr && !os_busy && !trig_wr) |=> !os_busy)
        else $error("abort outside a burst had an effect");

    chk_edges_tick: assert property (
        ($changed(os_state_ff == OS_RUN)) |-> $past(tick256))
        else $error("burst edge not on 256 Hz tick");

    chk_env_restart: assert property (
        env_restart_ok |=> (env_level_ff == LEVEL_MAX))
        else $error("envelope restart did not reach maximum");

    chk_env_hold: assert property (
        (env_level_ff == LEVEL_MIN && !env_restart_wr && !out_en_rise) |=> (env_level_ff == LEVEL_MIN))
        else $error("envelope left minimum level");

    chk_unused_zero: assert property (
        (bus_req.rd && bus_req.addr != ENV_CTRL_ADDR) |=> (rd_data[3] == 1'b0))
        else $error("unused bit read non-zero");

    chk_env_override: assert property (
        env_en_ff |-> (level_sel == env_level_ff))
        else $error("duty select used with envelope on");

    chk_long_len: assert property (
        (tick256 && pend_trig_ff && !trig_ok && pulse_len_ff) |=> (os_left_ff == PULSE_LONG_T))
        else $error("long one-shot length wrong");

endmodule : btg_top

`default_nettype wire

// >>> btg_wave.sv
// Tone waveform: divided period with a selectable active portion
`default_nettype none
`timescale 1ns/1ps

module btg_wave
    import btg_pkg::*;
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic       ce,
    // Timing and control
    input  wire logic       half_tick,
    input  wire logic       run,
    input  wire logic [2:0] freq_sel,
    input  wire logic [2:0] level,
    // Waveform, high while the pin is to be pulled active
    output logic            wave
);

    logic [5:0] phase_ff;
    logic [5:0] nxt_phase;
    logic       wave_ff;

    always_comb begin
        nxt_phase = phase_ff + 6'h01;
        if (nxt_phase >= btg_period(freq_sel)) begin
            nxt_phase = 6'h00;
        end
    end

    // Phase restarts when stopped so each burst opens with a full active part
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            phase_ff <= 6'h00;
        end else if (ce) begin
            if (!run) begin
                phase_ff <= 6'h00;
            end else if (half_tick) begin
                phase_ff <= nxt_phase;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wave_ff <= 1'b0;
        end else if (ce) begin
            wave_ff <= run && (phase_ff < btg_active_len(freq_sel, level));
        end
    end

    assign wave = wave_ff;

endmodule : btg_wave

`default_nettype wire

// >>> testbench.sv
// Self-checking bench of the buzzer tone generator
`default_nettype none
`timescale 1ns/1ps

module testbench;
    import btg_pkg::*;

    logic              clock;
    logic              rst_b;
    logic              ce;
    btg_bus_req_t      bus_req;
    logic [DATA_W-1:0] rd_data;
    logic              osc_in;
    logic              tone_output_pin;
    int                last_low;
    int                last_period;
    int                pulses;
    int                errors = 0;
    int                total_checks = 0;
    int                cyc = 0;
    int                t0;
    int                dur;
    int                p0;

    btg_top i_dut (
        .clock           (clock),
        .rst_b           (rst_b),
        .ce              (ce),
        .bus_req         (bus_req),
        .rd_data         (rd_data),
        .osc_in          (osc_in),
        .tone_output_pin (tone_output_pin)
    );

    btg_piezo_model i_piezo (
        .clock           (clock),
        .rst_b           (rst_b),
        .tone_output_pin (tone_output_pin),
        .last_low        (last_low),
        .last_period     (last_period),
        .pulses          (pulses)
    );

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // Oscillator far faster than real so one half tick is 4 clocks and the run stays short
    initial begin
        osc_in = 1'b0;
        forever begin
            repeat (4) @(posedge clock);
            osc_in <= ~osc_in;
        end
    end

    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            errors = errors + 1;
            close_out();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        if (errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_in(input int got, input int lo, input int hi);
        total_checks = total_checks + 1;
        if (got < lo || got > hi) begin
            errors = errors + 1;
            $display("CHECK FAILED at %0t: got %0h expected %0h to %0h", $time, got, lo, hi);
        end
    endtask : chk_in

    task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clock);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        bus_req <= '0;
    endtask : reg_wr

    // Read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clock);
        bus_req <= '{addr: a, wdata: 4'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        bus_req <= '0;
        #1 d = rd_data;
    endtask : reg_rd

    task automatic chk_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        logic [DATA_W-1:0] d;
        reg_rd(a, d);
        chk(32'(d), 32'(exp));
    endtask : chk_rd

    task automatic wait_idle(input int start, output int d);
        logic [DATA_W-1:0] s;
        int                n;
        s = 4'h2;
        n = 0;
        while (s[BIT_PULSE_TRIG] === 1'b1 && n < 20000) begin
            reg_rd(ONE_SHOT_ADDR, s);
            n = n + 1;
        end
        d = cyc - start;
    endtask : wait_idle

    task automatic tone(input logic [2:0] f, input logic [2:0] n);
        int per;
        int hi;
        per = (16 + 4 * f[1:0]) * (f[2] ? 2 : 1) * 4;
        hi  = ((f[1] ? 12 : 8) - n) * (f[2] ? 2 : 1) * 4;
        reg_wr(FREQ_SEL_ADDR, {1'b0, f});
        reg_wr(DUTY_SEL_ADDR, {1'b0, n});
        reg_wr(ENV_CTRL_ADDR, 4'h1);
        repeat (3 * per + 40) @(posedge clock);
        chk(32'(last_period), 32'(per));
        chk(32'(last_low), 32'(hi));
        reg_wr(ENV_CTRL_ADDR, 4'h0);
    endtask : tone

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_b   = 1'b0;
        ce      = 1'b1;
        bus_req = '0;
        repeat (10) @(posedge clock);
        rst_b <= 1'b1;
        for (int a = 0; a < 4; a++) begin
            chk_rd(ENV_CTRL_ADDR + 16'(a), 4'h0);
        end
        chk(32'(tone_output_pin), 32'h0000_0001);
        chk_rd(16'hff70, 4'h0);
        reg_wr(ENV_CTRL_ADDR, 4'hf);
        chk_rd(ENV_CTRL_ADDR, 4'hb);
        reg_wr(ENV_CTRL_ADDR, 4'h0);
        reg_wr(ONE_SHOT_ADDR, 4'hd);
        chk_rd(ONE_SHOT_ADDR, 4'h1);
        reg_wr(ONE_SHOT_ADDR, 4'h0);
        reg_wr(FREQ_SEL_ADDR, 4'hf);
        chk_rd(FREQ_SEL_ADDR, 4'h7);
        // A write while the clock enable is low must be lost
        @(posedge clock);
        ce <= 1'b0;
        reg_wr(FREQ_SEL_ADDR, 4'h2);
        ce <= 1'b1;
        chk_rd(FREQ_SEL_ADDR, 4'h7);
        reg_wr(DUTY_SEL_ADDR, 4'hf);
        chk_rd(DUTY_SEL_ADDR, 4'h7);
        // Every frequency, each with a different duty level
        for (int f = 0; f < 8; f++) begin
            tone(3'(f), 3'(f));
        end
        p0 = pulses;
        repeat (400) @(posedge clock);
        chk(32'(pulses), 32'(p0));
        chk(32'(tone_output_pin), 32'h0000_0001);
        // Envelope overrides duty select 7 and starts at maximum
        tone(3'h0, 3'h0);
        reg_wr(DUTY_SEL_ADDR, 4'h7);
        reg_wr(ENV_CTRL_ADDR, 4'h2);
        reg_wr(ENV_CTRL_ADDR, 4'h3);
        repeat (8000) @(posedge clock);
        chk(32'(last_low), 32'h0000_0020);
        repeat (10000) @(posedge clock);
        chk(32'(last_low), 32'h0000_001c);
        reg_wr(ENV_CTRL_ADDR, 4'h7);
        repeat (300) @(posedge clock);
        chk(32'(last_low), 32'h0000_0020);
        reg_wr(ENV_CTRL_ADDR, 4'hb);
        repeat (20000) @(posedge clock);
        chk(32'(last_low), 32'h0000_0020);
        reg_wr(ENV_CTRL_ADDR, 4'h1);
        reg_wr(ONE_SHOT_ADDR, 4'h2);
        chk_rd(ONE_SHOT_ADDR, 4'h0);
        reg_wr(ENV_CTRL_ADDR, 4'h0);
        // Short one-shot: start waits for the 256 Hz tick, then 8 ticks of tone
        p0 = pulses;
        reg_wr(ONE_SHOT_ADDR, 4'h2);
        t0 = cyc;
        chk_rd(ONE_SHOT_ADDR, 4'h2);
        wait_idle(t0, dur);
        chk_in(dur, 8192, 9240);
        chk_in(pulses - p0, 1, 4000);
        repeat (4) @(posedge clock);
        chk(32'(tone_output_pin), 32'h0000_0001);
        reg_wr(ONE_SHOT_ADDR, 4'h2);
        t0 = cyc;
        repeat (4000) @(posedge clock);
        reg_wr(ONE_SHOT_ADDR, 4'h2);
        wait_idle(t0, dur);
        chk_in(dur, 12192, 13240);
        // Long one-shot: still busy past any short length, then stopped early
        reg_wr(ONE_SHOT_ADDR, 4'h3);
        t0 = cyc;
        repeat (9300) @(posedge clock);
        chk_rd(ONE_SHOT_ADDR, 4'h3);
        reg_wr(ONE_SHOT_ADDR, 4'h4);
        wait_idle(t0, dur);
        chk_in(dur, 9300, 10400);
        close_out();
    end

endmodule : testbench

`default_nettype wire
